// file: design/config_set_manager.sv
// Configuration set manager: active set, factory setups, user slots, startup load
// What this block does
// - Active set lives in reset flip-flops and is lost on reset.
// - Three factory setups are constants; nothing can modify them.
// - Standard setup: low gain, all auto functions off.
// - High-gain setup: standard plus 6 dB of gain.
// - Auto setup: gain and exposure auto continuous, gain kept minimal.
// - Default-set choice is kept in storage that reset does not clear.
// - Default-set choice starts out as the standard setup.
// - Three user slots, numbered 1 to 3, kept across reset.
// - Save copies the active set into the selected slot, whole.
// - Lookup table values are never saved; they clear on reset.
// - Load overwrites the active set with the selected slot or default set.
// - Default-choice change is accepted only while acquisition is idle.
// - Load is performed only while acquisition is idle.
// - Startup selector chooses slot 1, 2, 3 or the default set.
// - After reset the startup set is copied into the active set.
`timescale 1ns/10ps
module config_set_manager (
   input  wire logic                           i_clk,
   input  wire logic                           i_reset_n,
   input  wire logic                           i_active_wr,
   input  wire logic [cfg_set_pkg::SET_W-1:0]  i_active_data,
   input  wire logic                           i_lut_wr,
   input  wire logic [cfg_set_pkg::LUT_W-1:0]  i_lut_data,
   input  wire logic [1:0]                     i_user_sel,
   input  wire logic                           i_save,
   input  wire logic                           i_load,
   input  wire logic [1:0]                     i_default_sel,
   input  wire logic                           i_default_wr,
   input  wire logic [1:0]                     i_startup_sel,
   input  wire logic                           i_startup_wr,
   input  wire logic                           i_acq_running,
   input  wire logic                           i_acq_pending,
   input  wire logic                           i_error_clr,
   output logic      [cfg_set_pkg::SET_W-1:0]  o_active_set,
   output logic      [cfg_set_pkg::LUT_W-1:0]  o_lut_data,
   output logic      [1:0]                     o_default_choice,
   output logic      [1:0]                     o_startup_choice,
   output logic                                o_boot_busy,
   output logic                                o_error,
   output logic                                o_done
);
   typedef struct packed {
      cfg_set_pkg::state_e             st;
      logic [cfg_set_pkg::SET_W-1:0]   active;
      logic [cfg_set_pkg::LUT_W-1:0]   lut;
      logic                            error;
      logic                            done;
   } state_s;

   state_s state_q;
   state_s state_d;

   // Storage that reset never touches; start values stand for the shipped state
   logic [cfg_set_pkg::SET_W-1:0] user_slot_q [1:cfg_set_pkg::USER_SLOTS] =
      '{default: factory(cfg_set_pkg::FACT_STANDARD)};
   logic [1:0]                    default_choice_q = cfg_set_pkg::FACT_STANDARD;
   logic [1:0]                    startup_choice_q = cfg_set_pkg::SEL_DEFAULT;

   logic                          idle;
   logic                          running;
   logic                          startup_ok;
   logic                          save_ok;
   logic                          load_ok;
   logic                          load_bad;
   logic                          dflt_ok;
   logic                          dflt_bad;
   logic [cfg_set_pkg::SET_W-1:0] factory_set;
   logic [cfg_set_pkg::SET_W-1:0] load_src;
   logic [cfg_set_pkg::SET_W-1:0] boot_src;

   // Factory setups are built from constants only, so no write path exists
   function automatic logic [cfg_set_pkg::SET_W-1:0] factory(input logic [1:0] code);
      logic [cfg_set_pkg::SET_W-1:0] s;
      s = '0;
      s[cfg_set_pkg::GAIN_LSB +: cfg_set_pkg::GAIN_W] = cfg_set_pkg::GAIN_LOW;
      s[cfg_set_pkg::GAIN_AUTO_LSB +: 2] = cfg_set_pkg::AUTO_OFF;
      s[cfg_set_pkg::EXPO_AUTO_LSB +: 2] = cfg_set_pkg::AUTO_OFF;
      case (code)
         cfg_set_pkg::FACT_HIGH_GAIN: begin
            s[cfg_set_pkg::GAIN_LSB +: cfg_set_pkg::GAIN_W] =
               cfg_set_pkg::GAIN_LOW + cfg_set_pkg::GAIN_HIGH_STEP;
         end
         cfg_set_pkg::FACT_AUTO: begin
            s[cfg_set_pkg::GAIN_AUTO_LSB +: 2] = cfg_set_pkg::AUTO_CONTINUOUS;
            s[cfg_set_pkg::EXPO_AUTO_LSB +: 2] = cfg_set_pkg::AUTO_CONTINUOUS;
            s[cfg_set_pkg::GAIN_MIN_BIT]       = 1'b1;
         end
         default: begin
         end
      endcase
      return s;
   endfunction

   // Selector 0 names the default set, which resolves to the chosen factory setup
   function automatic logic [cfg_set_pkg::SET_W-1:0] pick(input logic [1:0] sel,
                                                           input logic [cfg_set_pkg::SET_W-1:0] fs,
                                                           input logic [cfg_set_pkg::SET_W-1:0] u1,
                                                           input logic [cfg_set_pkg::SET_W-1:0] u2,
                                                           input logic [cfg_set_pkg::SET_W-1:0] u3);
      logic [cfg_set_pkg::SET_W-1:0] r;
      r = fs;
      case (sel)
         2'h1:    r = u1;
         2'h2:    r = u2;
         2'h3:    r = u3;
         default: r = fs;
      endcase
      return r;
   endfunction

   // Acquisition state comes from logic on this clock, so no synchroniser
   assign idle        = !i_acq_running && !i_acq_pending;
   assign factory_set = factory(default_choice_q);
   assign load_src    = pick(i_user_sel, factory_set,
                             user_slot_q[1], user_slot_q[2], user_slot_q[3]);
   assign boot_src    = pick(startup_choice_q, factory_set,
                             user_slot_q[1], user_slot_q[2], user_slot_q[3]);

   // Commands are ignored until the startup copy is done
   assign running    = (state_q.st == cfg_set_pkg::ST_RUN);
   assign startup_ok = i_startup_wr && running;

   // Save is allowed during acquisition: it only reads the active set
   always_comb begin
      save_ok  = 1'b0;
      load_ok  = 1'b0;
      load_bad = 1'b0;
      dflt_ok  = 1'b0;
      dflt_bad = 1'b0;
      if (running) begin
         save_ok  = i_save && (i_user_sel != cfg_set_pkg::SEL_DEFAULT);
         load_ok  = i_load && idle;
         load_bad = i_load && !idle;
         if (i_default_wr) begin
            if (!idle) begin
               dflt_bad = 1'b1;
            end else if (i_default_sel <= cfg_set_pkg::FACT_AUTO) begin
               // Code 3 names no setup, so it is dropped without an error
               dflt_ok = 1'b1;
            end
         end
      end
   end

   // No reset here on purpose: these model non-volatile contents
   always_ff @(posedge i_clk) begin
      if (dflt_ok) begin
         default_choice_q <= i_default_sel;
      end
   end

   always_ff @(posedge i_clk) begin
      if (startup_ok) begin
         startup_choice_q <= i_startup_sel;
      end
   end

   // A save in the cycle of a load or active write stores the old active set
   generate
      for (genvar g = 1; g <= cfg_set_pkg::USER_SLOTS; g++) begin : g_slot
         always_ff @(posedge i_clk) begin
            if (save_ok && (i_user_sel == 2'(g))) begin
               user_slot_q[g] <= state_q.active;
            end
         end
      end
   endgenerate

   always_comb begin
      state_d      = state_q;
      state_d.done = 1'b0;
      case (state_q.st)
         cfg_set_pkg::ST_BOOT: begin
            state_d.active = boot_src;
            state_d.st     = cfg_set_pkg::ST_RUN;
         end
         cfg_set_pkg::ST_RUN: begin
            if (i_active_wr) begin
               state_d.active = i_active_data;
            end
            if (load_ok) begin
               state_d.active = load_src;
            end
            if (i_lut_wr) begin
               state_d.lut = i_lut_data;
            end
            state_d.done = save_ok || load_ok || dflt_ok;
         end
         default: begin
            state_d.st = cfg_set_pkg::ST_BOOT;
         end
      endcase
      // Set wins over clear so a refusal in the clearing cycle is kept
      if (i_error_clr) begin
         state_d.error = 1'b0;
      end
      if (load_bad || dflt_bad) begin
         state_d.error = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q.st     <= cfg_set_pkg::ST_BOOT;
         state_q.active <= cfg_set_pkg::ACTIVE_RST;
         state_q.lut    <= cfg_set_pkg::LUT_RST;
         state_q.error  <= 1'b0;
         state_q.done   <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // Every output but o_boot_busy comes straight from a register; o_boot_busy is decoded from the state register
   assign o_active_set     = state_q.active;
   assign o_lut_data       = state_q.lut;
   assign o_default_choice = default_choice_q;
   assign o_startup_choice = startup_choice_q;
   assign o_boot_busy      = (state_q.st == cfg_set_pkg::ST_BOOT);
   assign o_error          = state_q.error;
   assign o_done           = state_q.done;
endmodule

// file: shared/cfg_set_pkg.sv
// Constants and types shared by the configuration set manager
package cfg_set_pkg;
   // One configuration set word
   localparam int          SET_W            = 32;
   localparam int          GAIN_W           = 8;
   localparam int          GAIN_LSB         = 0;
   localparam int          GAIN_AUTO_LSB    = 8;
   localparam int          EXPO_AUTO_LSB    = 10;
   localparam int          GAIN_MIN_BIT     = 12;
   localparam int          LUT_W            = 16;

   // Auto function modes
   localparam logic [1:0]  AUTO_OFF         = 2'h0;
   localparam logic [1:0]  AUTO_CONTINUOUS  = 2'h2;

   // Factory gain: low value plus the high-gain step in dB
   localparam logic [GAIN_W-1:0] GAIN_LOW       = 8'h00;
   localparam int                HIGH_GAIN_DB   = 6;
   localparam int                CODES_PER_DB   = 1;
   localparam logic [GAIN_W-1:0] GAIN_HIGH_STEP = GAIN_W'(HIGH_GAIN_DB * CODES_PER_DB);

   // Factory setup codes
   localparam logic [1:0]  FACT_STANDARD    = 2'h0;
   localparam logic [1:0]  FACT_HIGH_GAIN   = 2'h1;
   localparam logic [1:0]  FACT_AUTO        = 2'h2;

   // Set selector codes: 0 is the default set, 1 to 3 the user slots
   localparam logic [1:0]  SEL_DEFAULT      = 2'h0;
   localparam int          USER_SLOTS       = 3;

   // Reset values
   localparam logic [SET_W-1:0] ACTIVE_RST  = 32'h0000_0000;
   localparam logic [LUT_W-1:0] LUT_RST     = 16'h0000;

   typedef enum logic [1:0] {
      ST_BOOT = 2'b01,
      ST_RUN  = 2'b10
   } state_e;
endpackage

// file: bench/config_set_manager_asserts.sv
// Port checker for the configuration set manager
`timescale 1ns/10ps
module config_set_manager_asserts (
   input wire logic        i_clk,
   input wire logic        i_reset_n,
   input wire logic        i_active_wr,
   input wire logic [1:0]  i_user_sel,
   input wire logic        i_save,
   input wire logic        i_load,
   input wire logic [1:0]  i_default_sel,
   input wire logic        i_default_wr,
   input wire logic        i_acq_running,
   input wire logic        i_acq_pending,
   input wire logic        i_error_clr,
   input wire logic [31:0] o_active_set,
   input wire logic [1:0]  o_default_choice,
   input wire logic        o_boot_busy,
   input wire logic        o_error,
   input wire logic        o_done
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Boot cycle is excluded: commands are ignored there
   wire logic go = !o_boot_busy && !i_acq_running && !i_acq_pending;
   wire logic no = !o_boot_busy && (i_acq_running || i_acq_pending);
   chk_load_done: assert property (i_load && go |=> o_done)
      else $error("idle load gave no done");
   chk_load_refused: assert property (i_load && no && !i_active_wr |=> o_error && $stable(o_active_set))
      else $error("busy load not refused");
   chk_default_refused: assert property (i_default_wr && no |=> o_error && $stable(o_default_choice))
      else $error("busy default change not refused");
   chk_default_taken: assert property (i_default_wr && go && i_default_sel != 2'h3
      |=> o_done && o_default_choice == $past(i_default_sel)) else $error("default change lost");
   chk_high_gain: assert property (i_load && go && i_user_sel == 2'h0 && !i_default_wr
      && o_default_choice == 2'h1 |=> o_active_set == 32'h0000_0006) else $error("high gain set wrong");
   chk_active_hold: assert property (!i_active_wr && !i_load && !o_boot_busy |=> $stable(o_active_set))
      else $error("active set changed unasked");
   chk_error_sticky: assert property (o_error && !i_error_clr |=> o_error)
      else $error("error flag dropped");
   chk_done_cause: assert property (o_done |-> $past(i_save) || $past(i_load) || $past(i_default_wr))
      else $error("done without command");
   // Reset is released on a clock edge, so the release edge itself starts no attempt
   chk_boot_once: assert property (o_boot_busy && i_reset_n |=> !o_boot_busy)
      else $error("boot cycle did not end");
   cover property (i_save && !o_boot_busy ##1 o_done);
   cover property (i_load && no ##1 o_error);
   cover property (i_default_wr && go ##1 o_done);
endmodule
bind config_set_manager config_set_manager_asserts config_set_manager_asserts_i (.i_clk, .i_reset_n,
   .i_active_wr, .i_user_sel, .i_save, .i_load, .i_default_sel, .i_default_wr, .i_acq_running,
   .i_acq_pending, .i_error_clr, .o_active_set, .o_default_choice, .o_boot_busy, .o_error, .o_done);

// file: bench/host_model.sv
// Host software model driving selectors, command pulses and acquisition state
`timescale 1ns/10ps
module host_model (
   input  wire logic        i_clk,
   output logic [6:0]       o_pulse,
   output logic [1:0]       o_sel,
   output logic [31:0]      o_data,
   output logic [1:0]       o_acq
);
   initial begin
      o_pulse = '0;
      o_sel = '0;
      o_data = '0;
      o_acq = '0;
   end
   // Selector goes up with the command; data is inverted once the pulse ends so stale values never match
   task automatic cmd(input int k, input logic [1:0] s, input logic [31:0] d);
      @(posedge i_clk);
      o_sel <= s;
      o_data <= d;
      o_pulse <= 7'(1 << k);
      @(posedge i_clk);
      o_pulse <= '0;
      o_data <= ~d;
   endtask
   task automatic acq(input logic [1:0] a);
      @(posedge i_clk);
      o_acq <= a;
   endtask
endmodule

// file: bench/config_set_manager_tb_top.sv
// Self-checking bench for the configuration set manager
`timescale 1ns/10ps
module config_set_manager_tb_top;
   logic        clk = 0;
   logic        rst_n = 0;
   logic [6:0]  p;
   logic [1:0]  sel, acq, dch, sch;
   logic [31:0] dat, act, m, q[$];
   logic [31:0] slot[4] = '{default: 32'h0000_0000};
   logic [31:0] fs[3] = '{32'h0000_0000, 32'h0000_0006, 32'h0000_1a00};
   logic [15:0] lut;
   logic        busy, err, done;
   int          errors = 0, check_count = 0, seed = 17, ds[3] = '{2, 0, 1};
   always #5 clk = ~clk;
   host_model host_model_i (.i_clk(clk), .o_pulse(p), .o_sel(sel), .o_data(dat), .o_acq(acq));
   config_set_manager config_set_manager_i (.i_clk(clk), .i_reset_n(rst_n), .i_active_wr(p[0]),
      .i_active_data(dat), .i_lut_wr(p[1]), .i_lut_data(dat[15:0]), .i_user_sel(sel), .i_save(p[2]),
      .i_load(p[3]), .i_default_sel(sel), .i_default_wr(p[4]), .i_startup_sel(sel), .i_startup_wr(p[5]),
      .i_acq_running(acq[0]), .i_acq_pending(acq[1]), .i_error_clr(p[6]), .o_active_set(act),
      .o_lut_data(lut), .o_default_choice(dch), .o_startup_choice(sch), .o_boot_busy(busy),
      .o_error(err), .o_done(done));
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic cmp_flag(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED at %0t: flag got %b want %b", $time, g, e);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Every answer comes one cycle after its command, so a short fixed wait bounds it
   task automatic drain();
      repeat (4) @(posedge clk);
      if (q.size() != 0) begin
         errors++;
         $display("CHECK FAILED at %0t: %0d expected results never came", $time, q.size());
         print_verdict();
      end
   endtask
   // A done with no note waiting is itself a mismatch
   always @(posedge clk) begin
      #1;
      if (done === 1'b1) cmp(act, q.size() != 0 ? q.pop_front() : ~act);
   end
   initial begin
      repeat (12) @(posedge clk);
      cmp(act, 32'h0000_0000);
      cmp_flag(busy, 1'b1);
      rst_n <= 1;
      repeat (2) @(posedge clk);
      #1;
      cmp(act, fs[0]);
      cmp(dch, 2'h0);
      cmp_flag(busy, 1'b0);
      $display("test reset done");
      for (int s = 1; s <= 3; s++) begin
         m = $random(seed);
         host_model_i.cmd(0, 2'(s), m);
         q.push_back(m);
         host_model_i.cmd(2, 2'(s), 0);
         slot[s] = m;
      end
      host_model_i.cmd(2, 2'h0, 0);
      host_model_i.cmd(1, 0, 32'h0000_a5a5);
      drain();
      cmp(lut, 32'h0000_a5a5);
      $display("test save done");
      for (int s = 3; s >= 1; s--) begin
         q.push_back(slot[s]);
         host_model_i.cmd(3, 2'(s), 0);
      end
      m = slot[1];
      foreach (ds[i]) begin
         q.push_back(m);
         host_model_i.cmd(4, 2'(ds[i]), 0);
         m = fs[ds[i]];
         q.push_back(m);
         host_model_i.cmd(3, 2'h0, 0);
      end
      drain();
      $display("test load done");
      for (int a = 1; a <= 3; a++) begin
         host_model_i.acq(2'(a));
         host_model_i.cmd(3, 2'h1, 0);
         host_model_i.cmd(4, 2'h2, 0);
         #1;
         cmp_flag(err, 1'b1);
         cmp(act, m);
         cmp(dch, 2'h1);
         q.push_back(m);
         host_model_i.cmd(2, 2'h1, 0);
         host_model_i.cmd(6, 0, 0);
      end
      slot[1] = m;
      host_model_i.acq(2'h0);
      #1;
      cmp_flag(err, 1'b0);
      host_model_i.cmd(4, 2'h3, 0);
      #1;
      cmp(dch, 2'h1);
      cmp_flag(err, 1'b0);
      $display("test refusal done");
      host_model_i.cmd(5, 2'h2, 0);
      drain();
      rst_n <= 0;
      repeat (3) @(posedge clk);
      cmp(act, 32'h0000_0000);
      cmp_flag(busy, 1'b1);
      rst_n <= 1;
      repeat (2) @(posedge clk);
      #1;
      cmp(act, slot[2]);
      cmp(lut, 0);
      cmp(sch, 2'h2);
      cmp(dch, 2'h1);
      cmp_flag(busy, 1'b0);
      $display("test restart done");
      print_verdict();
   end
endmodule
